// [inc/regbank_params.svh]
/*
 Offsets, field positions, opcodes and reset values of the latency,
 interrupt and ECC self-test register bank.
 Assumes 24-bit register addresses on the serial link and one data byte
 per register access; wide registers take four consecutive addresses.
*/
`ifndef REGBANK_PARAMS_SVH
`define REGBANK_PARAMS_SVH

// Serial opcodes
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_REG_WRITE 8'h71
`define OP_REG_READ 8'h65

// Byte registers
`define ADDR_CFG 24'h000004
`define ADDR_CTRL 24'h000005
`define ADDR_DIE 24'h000006

// Word registers, byte address = word * 4 + lane, lane 0 is bits 7:0
`define WORD_DIN 22'h000004
`define WORD_MASK 22'h000005
`define WORD_DOUT 22'h000006
`define WORD_CNT 22'h000007

// Field positions
`define CFG_BLOCK_BIT 4
`define CFG_LAT_MSB 3
`define CFG_LAT_LSB 0
`define CTRL_FLAG_BIT 7
`define CTRL_CLR_BIT 6
`define CTRL_CNT_CLR_BIT 5
`define CTRL_TEST_BIT 1
`define CTRL_CORR_SEL_BIT 0

// Reset values
`define CFG_LAT_RESET 4'h8
`define CFG_BLOCK_RESET 1'h0
`define WORD_RESET 32'h00000000

`endif

// [inc/regbank_pkg.sv]
/*
 Types shared by the register bank, its serial link and its test engine.
 Assumes the includer also pulls in regbank_params.svh for constants.
*/
package regbank_pkg;

   typedef enum logic [5:0] {
      L_CMD    = 6'h01,
      L_ADDR   = 6'h02,
      L_DUMMY  = 6'h04,
      L_RDATA  = 6'h08,
      L_WDATA  = 6'h10,
      L_IGNORE = 6'h20
   } link_state_e;

   // Frame state, cleared whenever chip select is high
   typedef struct packed {
      link_state_e st;
      logic [4:0] bits;
      logic [3:0] dummy;
      logic [7:0] sh;
      logic [23:0] addr;
      logic [7:0] out_sh;
      logic cmd_rd;
   } link_frame_s;

   // Requests handed to the core clock domain, held between toggles
   typedef struct packed {
      logic [23:0] addr;
      logic [7:0] wdata;
      logic t_write_enable_latch;
      logic t_wrdi;
      logic t_wr;
      logic t_rd;
   } link_req_s;

   typedef struct packed {
      link_req_s req;
      logic [3:0] lat_s1;
      logic [3:0] lat_s2;
   } link_held_s;

   typedef struct packed {
      logic so;
      logic oe;
   } link_out_s;

   typedef struct packed {
      logic [31:0] result;
      logic corr;
      logic uncorr;
   } eng_s;

   typedef struct packed {
      logic [3:0] lat;
      logic block;
      logic corr_sel;
      logic test_en;
      logic [1:0] die;
      logic flag;
      logic corr_pend;
      logic [31:0] din;
      logic [31:0] mask;
      logic [31:0] cnt;
      logic wel;
      logic wr_seen;
      logic int_n;
      logic [7:0] rd_byte;
      logic eng_start;
      logic [2:0] s_write_enable_latch;
      logic [2:0] s_wrdi;
      logic [2:0] s_wr;
      logic [2:0] s_rd;
      logic [2:0] s_cs;
   } core_s;

endpackage

// [rtl/serial_reg_link.sv]
/*
 Serial side of the register bank: single-lane command, address, dummy
 and data phases, clocked by the host's serial clock.
 Assumes SCK idles between frames, MSB first, input sampled on the rising
 edge and output launched on the falling edge; read data must be stable
 from the core by the last dummy edge.
*/
`timescale 1ns/1ps
`include "regbank_params.svh"

module serial_reg_link (
   // Link
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic si_in,
   output logic so_out,
   output logic so_oe_out,
   // Core side
   input wire logic reset_in,
   input wire logic [3:0] lat_in,
   input wire logic [7:0] rd_byte_in,
   output regbank_pkg::link_req_s req_out
);

   regbank_pkg::link_frame_s f_r;
   regbank_pkg::link_frame_s f_nxt;
   regbank_pkg::link_held_s h_r;
   regbank_pkg::link_held_s h_nxt;
   regbank_pkg::link_out_s o_r;
   logic frame_rst;
   logic [7:0] shifted;
   logic [23:0] addr_sh;

   assign frame_rst = reset_in | cs_n_in;
   assign req_out = h_r.req;
   assign so_out = o_r.so;
   assign so_oe_out = o_r.oe;

   always_comb begin
      f_nxt = f_r;
      h_nxt = h_r;
      shifted = {f_r.sh[6:0], si_in};
      addr_sh = {f_r.addr[22:0], si_in};
      h_nxt.lat_s1 = lat_in;
      h_nxt.lat_s2 = h_r.lat_s1;
      case (f_r.st)
         regbank_pkg::L_CMD: begin
            f_nxt.sh = shifted;
            f_nxt.bits = f_r.bits + 5'h01;
            if (f_r.bits == 5'h07) begin
               f_nxt.bits = 5'h00;
               f_nxt.cmd_rd = (shifted == `OP_REG_READ);
               f_nxt.st = regbank_pkg::L_IGNORE;
               if (shifted == `OP_WRITE_ENABLE) begin
                  h_nxt.req.t_write_enable_latch = ~h_r.req.t_write_enable_latch;
               end else if (shifted == `OP_WRITE_DISABLE) begin
                  h_nxt.req.t_wrdi = ~h_r.req.t_wrdi;
               end else if (shifted == `OP_REG_WRITE ||
                            shifted == `OP_REG_READ) begin
                  f_nxt.st = regbank_pkg::L_ADDR;
               end
            end
         end
         regbank_pkg::L_ADDR: begin
            f_nxt.addr = addr_sh;
            f_nxt.bits = f_r.bits + 5'h01;
            if (f_r.bits == 5'h17) begin
               f_nxt.bits = 5'h00;
               if (f_r.cmd_rd) begin
                  // Ask early so the byte is ready after the dummy phase
                  h_nxt.req.addr = addr_sh;
                  h_nxt.req.t_rd = ~h_r.req.t_rd;
                  if (h_r.lat_s2 == 4'h0) begin
                     f_nxt.st = regbank_pkg::L_RDATA;
                     f_nxt.out_sh = rd_byte_in;
                  end else begin
                     f_nxt.st = regbank_pkg::L_DUMMY;
                  end
               end else begin
                  f_nxt.st = regbank_pkg::L_WDATA;
               end
            end
         end
         regbank_pkg::L_DUMMY: begin
            f_nxt.dummy = f_r.dummy + 4'h1;
            if (f_r.dummy + 4'h1 == h_r.lat_s2) begin
               f_nxt.st = regbank_pkg::L_RDATA;
               f_nxt.out_sh = rd_byte_in;
            end
         end
         regbank_pkg::L_RDATA: begin
            // Further clocks repeat the same byte
            f_nxt.out_sh = {f_r.out_sh[6:0], f_r.out_sh[7]};
         end
         regbank_pkg::L_WDATA: begin
            f_nxt.sh = shifted;
            f_nxt.bits = f_r.bits + 5'h01;
            if (f_r.bits == 5'h07) begin
               h_nxt.req.addr = f_r.addr;
               h_nxt.req.wdata = shifted;
               h_nxt.req.t_wr = ~h_r.req.t_wr;
               f_nxt.st = regbank_pkg::L_IGNORE;
            end
         end
         regbank_pkg::L_IGNORE: begin
            f_nxt.st = regbank_pkg::L_IGNORE;
         end
         default: begin
            f_nxt.st = regbank_pkg::L_IGNORE;
         end
      endcase
   end

   always_ff @(posedge sck_in or posedge frame_rst) begin
      if (frame_rst) begin
         f_r <= '{st: regbank_pkg::L_CMD, default: '0};
      end else begin
         f_r <= f_nxt;
      end
   end

   always_ff @(posedge sck_in or posedge reset_in) begin
      if (reset_in) begin
         h_r <= '0;
      end else begin
         h_r <= h_nxt;
      end
   end

   always_ff @(negedge sck_in or posedge frame_rst) begin
      if (frame_rst) begin
         o_r <= '0;
      end else begin
         o_r.so <= f_r.out_sh[7];
         o_r.oe <= (f_r.st == regbank_pkg::L_RDATA);
      end
   end

   dummy_bound_a: assert property (@(posedge sck_in) disable iff (frame_rst)
      f_r.st == regbank_pkg::L_DUMMY |-> f_r.dummy < h_r.lat_s2)
      else $error("dummy phase ran past the latency setting");

endmodule

// [rtl/ecc_selftest_engine.sv]
/*
 Stand-in ECC engine for self-test: the test word with its flip mask
 applied is judged clean, corrected or uncorrectable.
 Assumes start is a one-cycle pulse on the core clock with stable inputs.
*/
`timescale 1ns/1ps

module ecc_selftest_engine (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Test word
   input wire logic start_in,
   input wire logic [31:0] data_in,
   input wire logic [31:0] mask_in,
   // Result
   output logic [31:0] result_out,
   output logic corrected_out,
   output logic uncorrectable_out
);

   regbank_pkg::eng_s e_r;
   regbank_pkg::eng_s e_nxt;
   logic [31:0] flipped;
   logic single;

   assign result_out = e_r.result;
   assign corrected_out = e_r.corr;
   assign uncorrectable_out = e_r.uncorr;

   always_comb begin
      e_nxt = e_r;
      e_nxt.corr = 1'h0;
      e_nxt.uncorr = 1'h0;
      flipped = data_in ^ mask_in;
      single = (mask_in != 32'h0) &&
         ((mask_in & (mask_in - 32'h1)) == 32'h0);
      if (start_in) begin
         if (mask_in == 32'h0) begin
            e_nxt.result = data_in;
         end else if (single) begin
            e_nxt.result = data_in;
            e_nxt.corr = 1'h1;
         end else begin
            e_nxt.result = flipped;
            e_nxt.uncorr = 1'h1;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         e_r <= '0;
      end else begin
         e_r <= e_nxt;
      end
   end

   multi_flip_a: assert property (@(posedge clk_in) disable iff (rst_in)
      start_in && !single && mask_in != 32'h0 |=>
      uncorrectable_out && result_out == $past(flipped))
      else $error("multi-bit flip not reported with masked word");

   single_fix_a: assert property (@(posedge clk_in) disable iff (rst_in)
      start_in && single |=> corrected_out && !uncorrectable_out &&
      result_out == $past(data_in))
      else $error("single-bit flip not corrected");

endmodule

// [rtl/latency_interrupt_ecc_test_regs.sv]
/*
 Latency, interrupt and ECC self-test register bank, reached by the
 register write and read commands on the serial link.
 Assumes the serial clock is a separate domain; array ECC events arrive as
 one-cycle pulses on REF_CLK_IN.
*/
`timescale 1ns/1ps
`include "regbank_params.svh"

module latency_interrupt_ecc_test_regs (
   // Clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RESET_IN,
   // Serial link
   input wire logic SCK_IN,
   input wire logic CS_N_IN,
   input wire logic SI_IN,
   output logic SO_OUT,
   output logic SO_OE_OUT,
   // Array ECC events
   input wire logic ARRAY_ECC_CORR_IN,
   input wire logic ARRAY_ECC_UNCORR_IN,
   // Controls and interrupt
   output logic [3:0] READ_WAIT_CYCLES_OUT,
   output logic INPLACE_WRITE_BLOCK_OUT,
   output logic SELFTEST_ENABLE_OUT,
   output logic [1:0] DIE_SELECT_OUT,
   output logic WRITE_ENABLE_LATCH_OUT,
   output logic INT_N_OUT
);

   regbank_pkg::core_s c_r;
   regbank_pkg::core_s c_nxt;
   regbank_pkg::link_req_s req;
   logic [31:0] eng_result;
   logic eng_corr;
   logic eng_uncorr;
   logic write_enable_latch_evt;
   logic wrdi_evt;
   logic wr_evt;
   logic rd_evt;
   logic cs_rise;
   logic wr_ok;
   logic clr_req;
   logic cnt_clr;
   logic corr_evt;
   logic uncorr_evt;
   logic [23:0] a;
   logic [4:0] lane;

   serial_reg_link serial_reg_link_inst (
      .sck_in(SCK_IN),
      .cs_n_in(CS_N_IN),
      .si_in(SI_IN),
      .so_out(SO_OUT),
      .so_oe_out(SO_OE_OUT),
      .reset_in(RESET_IN),
      .lat_in(c_r.lat),
      .rd_byte_in(c_r.rd_byte),
      .req_out(req)
   );

   ecc_selftest_engine ecc_selftest_engine_inst (
      .clk_in(REF_CLK_IN),
      .rst_in(RESET_IN),
      .start_in(c_r.eng_start),
      .data_in(c_r.din),
      .mask_in(c_r.mask),
      .result_out(eng_result),
      .corrected_out(eng_corr),
      .uncorrectable_out(eng_uncorr)
   );

   assign READ_WAIT_CYCLES_OUT = c_r.lat;
   assign INPLACE_WRITE_BLOCK_OUT = c_r.block;
   assign SELFTEST_ENABLE_OUT = c_r.test_en;
   assign DIE_SELECT_OUT = c_r.die;
   assign WRITE_ENABLE_LATCH_OUT = c_r.wel;
   assign INT_N_OUT = c_r.int_n;

   // Toggle events: stage 0 samples, stages 1 and 2 are compared for the edge
   assign write_enable_latch_evt = c_r.s_write_enable_latch[1] ^ c_r.s_write_enable_latch[2];
   assign wrdi_evt = c_r.s_wrdi[1] ^ c_r.s_wrdi[2];
   assign wr_evt = c_r.s_wr[1] ^ c_r.s_wr[2];
   assign rd_evt = c_r.s_rd[1] ^ c_r.s_rd[2];
   assign cs_rise = c_r.s_cs[1] & ~c_r.s_cs[2];
   assign a = req.addr;
   assign lane = {a[1:0], 3'h0};

   always_comb begin
      c_nxt = c_r;
      c_nxt.s_write_enable_latch = {c_r.s_write_enable_latch[1:0], req.t_write_enable_latch};
      c_nxt.s_wrdi = {c_r.s_wrdi[1:0], req.t_wrdi};
      c_nxt.s_wr = {c_r.s_wr[1:0], req.t_wr};
      c_nxt.s_rd = {c_r.s_rd[1:0], req.t_rd};
      c_nxt.s_cs = {c_r.s_cs[1:0], CS_N_IN};
      c_nxt.eng_start = 1'h0;
      wr_ok = wr_evt && c_r.wel;
      clr_req = 1'h0;
      cnt_clr = 1'h0;

      if (wr_ok) begin
         c_nxt.wr_seen = 1'h1;
         if (a == `ADDR_CFG) begin
            c_nxt.block = req.wdata[`CFG_BLOCK_BIT];
            c_nxt.lat = req.wdata[`CFG_LAT_MSB:`CFG_LAT_LSB];
         end else if (a == `ADDR_CTRL) begin
            c_nxt.corr_sel = req.wdata[`CTRL_CORR_SEL_BIT];
            c_nxt.test_en = req.wdata[`CTRL_TEST_BIT];
            clr_req = req.wdata[`CTRL_CLR_BIT];
            cnt_clr = req.wdata[`CTRL_CNT_CLR_BIT];
            c_nxt.eng_start = req.wdata[`CTRL_TEST_BIT] & ~c_r.test_en;
         end else if (a == `ADDR_DIE) begin
            c_nxt.die = req.wdata[1:0];
         end else if (a[23:2] == `WORD_DIN) begin
            c_nxt.din[lane +: 8] = req.wdata;
            c_nxt.eng_start = c_r.test_en;
         end else if (a[23:2] == `WORD_MASK) begin
            c_nxt.mask[lane +: 8] = req.wdata;
            c_nxt.eng_start = c_r.test_en;
         end
      end

      // Latch: frame end after a write clears, enable command sets
      if (cs_rise && c_r.wr_seen) begin
         c_nxt.wel = 1'h0;
         c_nxt.wr_seen = 1'h0;
      end
      if (wrdi_evt) begin
         c_nxt.wel = 1'h0;
      end
      if (write_enable_latch_evt) begin
         c_nxt.wel = 1'h1;
      end

      // Clears act first so that a same-cycle event still lands
      corr_evt = eng_corr | ARRAY_ECC_CORR_IN;
      uncorr_evt = eng_uncorr | ARRAY_ECC_UNCORR_IN;
      if (clr_req) begin
         c_nxt.flag = 1'h0;
         c_nxt.corr_pend = 1'h0;
      end
      if (uncorr_evt) begin
         c_nxt.flag = 1'h1;
      end
      if (corr_evt && c_r.corr_sel) begin
         c_nxt.corr_pend = 1'h1;
      end
      if (cnt_clr) begin
         c_nxt.cnt = `WORD_RESET;
      end
      if (eng_uncorr) begin
         c_nxt.cnt = c_nxt.cnt + 32'h1;
      end
      c_nxt.int_n = ~(c_nxt.flag | c_nxt.corr_pend);

      if (rd_evt) begin
         c_nxt.rd_byte = 8'h00;
         if (a == `ADDR_CFG) begin
            c_nxt.rd_byte = {3'h0, c_r.block, c_r.lat};
         end else if (a == `ADDR_CTRL) begin
            c_nxt.rd_byte = {c_r.flag, 7'h00};
         end else if (a == `ADDR_DIE) begin
            c_nxt.rd_byte = {6'h00, c_r.die};
         end else if (a[23:2] == `WORD_DIN) begin
            c_nxt.rd_byte = c_r.din[lane +: 8];
         end else if (a[23:2] == `WORD_MASK) begin
            c_nxt.rd_byte = c_r.mask[lane +: 8];
         end else if (a[23:2] == `WORD_DOUT) begin
            c_nxt.rd_byte = eng_result[lane +: 8];
         end else if (a[23:2] == `WORD_CNT) begin
            c_nxt.rd_byte = c_r.cnt[lane +: 8];
         end
      end
   end

   always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         c_r <= '{lat: `CFG_LAT_RESET, block: `CFG_BLOCK_RESET,
            int_n: 1'h1, s_cs: 3'h7, default: '0};
      end else begin
         c_r <= c_nxt;
      end
   end

   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (RESET_IN);

   wel_gate_a: assert property (wr_evt && !c_r.wel |=>
      c_r.lat == $past(c_r.lat) && c_r.block == $past(c_r.block))
      else $error("register changed without write enable latch");

   wel_clear_a: assert property (cs_rise && c_r.wr_seen &&
      !write_enable_latch_evt |=> !c_r.wel)
      else $error("latch survived end of write frame");

   flag_int_a: assert property (c_r.flag |-> !INT_N_OUT)
      else $error("flag set but interrupt high");

   flag_hold_a: assert property (c_r.flag && !clr_req |=>
      c_r.flag && !INT_N_OUT)
      else $error("flag dropped without clear");

   uncorr_flag_a: assert property (eng_uncorr |=>
      c_r.flag ##1 !INT_N_OUT)
      else $error("uncorrectable error did not set flag");

   tally_inc_a: assert property (eng_uncorr && !cnt_clr |=>
      c_r.cnt == $past(c_r.cnt) + 32'h1)
      else $error("tally did not count test error");

   tally_clear_a: assert property (cnt_clr && !eng_uncorr |=>
      c_r.cnt == 32'h0)
      else $error("tally not cleared");

   corr_route_a: assert property (corr_evt && c_r.corr_sel &&
      !clr_req |=> !INT_N_OUT)
      else $error("selected correction event missed interrupt");

   ctrl_read_a: assert property (rd_evt && a == `ADDR_CTRL |=>
      c_r.rd_byte[6:0] == 7'h00)
      else $error("write-only control bits read nonzero");

   // Register writes land in the next cycle
   block_write_a: assert property (wr_ok && a == `ADDR_CFG |=>
      INPLACE_WRITE_BLOCK_OUT == $past(req.wdata[`CFG_BLOCK_BIT]))
      else $error("write-block bit not written");

   lat_write_a: assert property (wr_ok && a == `ADDR_CFG |=>
      READ_WAIT_CYCLES_OUT == $past(req.wdata[`CFG_LAT_MSB:`CFG_LAT_LSB]))
      else $error("wait cycle field not written");

   test_mode_a: assert property (wr_ok && a == `ADDR_CTRL |=>
      SELFTEST_ENABLE_OUT == $past(req.wdata[`CTRL_TEST_BIT]))
      else $error("test enable bit not written");

   die_write_a: assert property (wr_ok && a == `ADDR_DIE |=>
      DIE_SELECT_OUT == $past(req.wdata[1:0]))
      else $error("die select not written");

   // Latch commands
   write_enable_latch_set_a: assert property (write_enable_latch_evt |=> WRITE_ENABLE_LATCH_OUT)
      else $error("write enable command did not set latch");

   wrdi_clear_a: assert property (wrdi_evt && !write_enable_latch_evt |=>
      !WRITE_ENABLE_LATCH_OUT)
      else $error("write disable command did not clear latch");

   // Interrupt and flag
   clear_flag_a: assert property (clr_req && !uncorr_evt |=>
      !c_r.flag)
      else $error("clear bit did not drop flag");

   int_low_a: assert property (uncorr_evt |=> !INT_N_OUT)
      else $error("uncorrectable event left interrupt high");

   corr_quiet_a: assert property (corr_evt && !c_r.corr_sel &&
      !uncorr_evt && INT_N_OUT |=> INT_N_OUT)
      else $error("unselected correction event pulled interrupt");

   int_keep_a: assert property (!INT_N_OUT && !clr_req |=>
      !INT_N_OUT)
      else $error("interrupt released without clear");

   // Tally, result and read-back
   cnt_hold_a: assert property (!eng_uncorr && !cnt_clr |=>
      $stable(c_r.cnt))
      else $error("tally moved without test error");

   result_hold_a: assert property (!c_r.eng_start |=>
      $stable(eng_result))
      else $error("result word changed without engine run");

   cfg_read_a: assert property (rd_evt && a == `ADDR_CFG |=>
      c_r.rd_byte[7:5] == 3'h0)
      else $error("reserved config bits read nonzero");

   die_read_a: assert property (rd_evt && a == `ADDR_DIE |=>
      c_r.rd_byte[7:2] == 6'h00)
      else $error("reserved die bits read nonzero");

endmodule

// [verification/spi_host_model.sv]
/*
 Host model for the register bank's serial link: single-lane frames with
 a 125 ns serial clock that stands still low outside frames.
 Assumes the bench calls one task at a time, with chip select left high
 through reset.
*/
`timescale 1ns/1ps
`include "regbank_params.svh"

module spi_host_model (
   // Link
   output logic sck_out,
   output logic cs_n_out,
   output logic si_out,
   input wire logic so_in,
   input wire logic so_oe_in
);
   localparam realtime HALF = 62.5;

   // Wait cycles the host expects; never zero at this clock rate
   logic [3:0] lat = 4'h8;

   initial begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      si_out = 1'b0;
   end

   task automatic send(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         si_out = v[i];
         #HALF sck_out = 1'b1;
         #HALF sck_out = 1'b0;
      end
   endtask

   task automatic begin_frame;
      cs_n_out = 1'b0;
      #HALF;
   endtask

   // Released data line shows the inverse of its last bit
   task automatic end_frame;
      #HALF cs_n_out = 1'b1;
      si_out = ~si_out;
      #300;
   endtask

   task automatic cmd(input logic [7:0] op);
      begin_frame();
      send({24'h0, op}, 8);
      end_frame();
   endtask

   // Writes go by address and rely on an earlier write enable frame
   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      begin_frame();
      send({`OP_REG_WRITE, a}, 32);
      send({24'h0, d}, 8);
      end_frame();
   endtask

   task automatic rd(input logic [23:0] a, output logic [7:0] d,
                     output logic oe);
      begin_frame();
      send({`OP_REG_READ, a}, 32);
      for (int i = 0; i < lat; i++) begin
         send({31'h0, ~si_out}, 1);
      end
      oe = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         si_out = ~si_out;
         #HALF sck_out = 1'b1;
         d[i] = so_in;
         oe = oe & so_oe_in;
         #HALF sck_out = 1'b0;
      end
      end_frame();
   endtask
endmodule

// [verification/tb_latency_interrupt_ecc_test_regs.sv]
/*
 Self-checking bench for the latency, interrupt and ECC self-test bank.
 Assumes the host model drives the serial link; array ECC events are
 pulsed on the core clock.
*/
`timescale 1ns/1ps
`include "regbank_params.svh"

module tb_latency_interrupt_ecc_test_regs;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic ecc_corr = 1'b0;
   logic ecc_uncorr = 1'b0;
   logic sck, cs_n, si, so, so_oe;
   logic [3:0] lat;
   logic [1:0] die;
   logic block, test_en, wel, int_n;
   logic [7:0] cfgs [3] = '{8'h0f, 8'h01, 8'h08};
   int err_total = 0;
   int cmp_count = 0;

   always #10 ref_clk = ~ref_clk;

   latency_interrupt_ecc_test_regs latency_interrupt_ecc_test_regs_inst (
      .REF_CLK_IN(ref_clk), .RESET_IN(reset), .SCK_IN(sck),
      .CS_N_IN(cs_n), .SI_IN(si), .SO_OUT(so), .SO_OE_OUT(so_oe),
      .ARRAY_ECC_CORR_IN(ecc_corr), .ARRAY_ECC_UNCORR_IN(ecc_uncorr),
      .READ_WAIT_CYCLES_OUT(lat), .INPLACE_WRITE_BLOCK_OUT(block),
      .SELFTEST_ENABLE_OUT(test_en), .DIE_SELECT_OUT(die),
      .WRITE_ENABLE_LATCH_OUT(wel), .INT_N_OUT(int_n));

   spi_host_model spi_host_model_inst (
      .sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so),
      .so_oe_in(so_oe));

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      @(negedge ref_clk);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask

   task automatic wre(input logic [23:0] a, input logic [7:0] d);
      spi_host_model_inst.cmd(`OP_WRITE_ENABLE);
      spi_host_model_inst.wr(a, d);
   endtask

   task automatic rdchk(input logic [23:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic oe;
      spi_host_model_inst.rd(a, d, oe);
      check("read data", {24'h0, exp}, {24'h0, d});
      check("output enable", 32'h1, {31'h0, oe});
   endtask

   task automatic wr32(input logic [21:0] w, input logic [31:0] v);
      for (int i = 0; i < 4; i++) begin
         wre({w, 2'(i)}, v[8*i +: 8]);
      end
   endtask

   task automatic rd32chk(input logic [21:0] w, input logic [31:0] exp);
      for (int i = 0; i < 4; i++) begin
         rdchk({w, 2'(i)}, exp[8*i +: 8]);
      end
   endtask

   task automatic pulse(input bit uncorr);
      @(posedge ref_clk);
      #1 {ecc_uncorr, ecc_corr} = uncorr ? 2'b10 : 2'b01;
      @(posedge ref_clk);
      #1 {ecc_uncorr, ecc_corr} = 2'b00;
   endtask

   initial begin
      #1500000;
      err_total++;
      stop_test();
   end

   initial begin
      repeat (12) @(posedge ref_clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge ref_clk);
      check("wait cycles", 32'h8, {28'h0, lat});
      check("xip block", 32'h0, {31'h0, block});
      check("interrupt", 32'h1, {31'h0, int_n});
      check("test enable", 32'h0, {31'h0, test_en});
      rdchk(`ADDR_CTRL, 8'h00);
      rd32chk(`WORD_DIN, 32'h0);
      rd32chk(`WORD_MASK, 32'h0);
      rd32chk(`WORD_DOUT, 32'h0);
      end_test("reset");

      spi_host_model_inst.wr(`ADDR_CFG, 8'h1c);
      rdchk(`ADDR_CFG, 8'h08);
      spi_host_model_inst.cmd(`OP_WRITE_ENABLE);
      check("latch", 32'h1, {31'h0, wel});
      spi_host_model_inst.wr(`ADDR_CFG, 8'hfc);
      check("latch", 32'h0, {31'h0, wel});
      check("xip block", 32'h1, {31'h0, block});
      check("wait cycles", 32'hc, {28'h0, lat});
      spi_host_model_inst.lat = 4'hc;
      rdchk(`ADDR_CFG, 8'h1c);
      foreach (cfgs[i]) begin
         wre(`ADDR_CFG, cfgs[i]);
         spi_host_model_inst.lat = cfgs[i][3:0];
         check("wait cycles", {28'h0, cfgs[i][3:0]}, {28'h0, lat});
         check("xip block", 32'h0, {31'h0, block});
         rdchk(`ADDR_CFG, cfgs[i]);
      end
      spi_host_model_inst.cmd(`OP_WRITE_ENABLE);
      spi_host_model_inst.cmd(`OP_WRITE_DISABLE);
      check("latch", 32'h0, {31'h0, wel});
      spi_host_model_inst.wr(`ADDR_CFG, 8'h1f);
      check("wait cycles", 32'h8, {28'h0, lat});
      wre(`ADDR_DIE, 8'h03);
      check("die", 32'h3, {30'h0, die});
      end_test("config");

      wr32(`WORD_DIN, 32'h12345678);
      rd32chk(`WORD_DIN, 32'h12345678);
      wr32(`WORD_MASK, 32'h00000003);
      check("interrupt", 32'h1, {31'h0, int_n});
      wre(`ADDR_CTRL, 8'h02);
      check("test enable", 32'h1, {31'h0, test_en});
      check("interrupt", 32'h0, {31'h0, int_n});
      rdchk(`ADDR_CTRL, 8'h80);
      rd32chk(`WORD_DOUT, 32'h1234567b);
      // Tally read is not gated by test mode, which is on here
      rd32chk(`WORD_CNT, 32'h1);
      wre(`ADDR_CTRL, 8'h02);
      check("interrupt", 32'h0, {31'h0, int_n});
      wre(`ADDR_CTRL, 8'h42);
      check("interrupt", 32'h1, {31'h0, int_n});
      rdchk(`ADDR_CTRL, 8'h00);
      rd32chk(`WORD_CNT, 32'h1);
      wre(`ADDR_CTRL, 8'h22);
      rd32chk(`WORD_CNT, 32'h0);
      end_test("uncorrectable");

      wre({`WORD_MASK, 2'd0}, 8'h01);
      check("interrupt", 32'h1, {31'h0, int_n});
      rd32chk(`WORD_DOUT, 32'h12345678);
      wre(`ADDR_CTRL, 8'h03);
      wre({`WORD_MASK, 2'd0}, 8'h01);
      check("interrupt", 32'h0, {31'h0, int_n});
      rdchk(`ADDR_CTRL, 8'h00);
      rd32chk(`WORD_CNT, 32'h0);
      wre(`ADDR_CTRL, 8'h43);
      check("interrupt", 32'h1, {31'h0, int_n});
      wre({`WORD_DOUT, 2'd0}, 8'hff);
      rd32chk(`WORD_DOUT, 32'h12345678);
      rdchk(24'h00007f, 8'h00);
      pulse(1'b0);
      check("interrupt", 32'h0, {31'h0, int_n});
      wre(`ADDR_CTRL, 8'h41);
      check("interrupt", 32'h1, {31'h0, int_n});
      pulse(1'b1);
      check("interrupt", 32'h0, {31'h0, int_n});
      rdchk(`ADDR_CTRL, 8'h80);
      wre(`ADDR_CTRL, 8'h40);
      check("interrupt", 32'h1, {31'h0, int_n});
      end_test("correctable");
      stop_test();
   end
endmodule
